// ### common/debug_ctl_pkg.sv
// constants shared by the debug mode control block
package debug_ctl_pkg;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 4;
  localparam int CORE_EV_W = 27;
  localparam int CNT_W     = 16;

  // register indices
  localparam logic [ADDR_W-1:0] ADDR_INSTRUCTION_SUPPORT_CONTROL  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_LCTRL  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DEN    = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CNT_I  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CNT_L  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_PDATA  = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;

  // trap enable fields in both support control registers
  localparam int TE_SW_BIT   = 0;
  localparam int TE_PORT_BIT = 1;

  // trap enable frame payload
  localparam int PL_ITE   = 0;
  localparam int PL_LTE   = 1;
  localparam int PL_NMBK  = 2;
  localparam int PL_MBK   = 3;
  localparam int PL_VS_LO = 4;
  localparam logic [1:0] VSYNC_ON  = 2'h1;
  localparam logic [1:0] VSYNC_OFF = 2'h2;

  // cause register bit positions
  localparam int CAUSE_PORT_NM = 31;
  localparam int CAUSE_PORT_M  = 30;
  localparam int CAUSE_PERIPH  = 29;
  localparam int CAUSE_IBRK    = 28;
  localparam int CAUSE_LBRK    = 27;

  // status fields
  localparam int ST_DEN = 0;
  localparam int ST_DBG = 1;

  // reset values
  localparam logic [DATA_W-1:0] DEN_RESET = 32'hffffffff;
  localparam logic [CNT_W-1:0]  CNT_RESET = 16'h0000;

  // timing in core clocks
  localparam int SAMPLE_LEAD = 3;
  localparam int ENTRY_HOLD  = 7;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_DRAIN,
    ST_DEBUG
  } dbg_state_t;
endpackage : debug_ctl_pkg

// ### hw/debug_mode_control.sv
// debug mode, trap enable and development port control logic
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps

// Summary of operation
// - instruction counter break at count one suppresses execution; counter stays 1
// - load/store counter break after completion; counter reads zero
// - software trap enables writable only with privilege level bit zero
// - effective trap enable is software bit OR port bit
// - both trap enable copies readable in the support control registers
// - debug enable chosen once at reset, held until next reset
// - serial clock pin sampled three clocks before soft reset negation
// - pin sampled negated keeps debug disabled until a later reset
// - watchpoint and breakpoint logic works with debug disabled
// - in debug mode instructions come from the port, data from memory
// - debug mode forces the privileged state
// - return-from-interrupt in debug mode resumes normal mode
// - OR of all cause bits is presented to the port
// - each event goes to its vector or to debug entry by enable bit
// - trap enable frames carry five controls including the sync code
// - port nonmaskable request enters debug even with interrupts off
// - execution resumes where debug mode was entered
// - full-duplex serial port sampled on the core clock, slower tool clock
// - entry sources: two port request levels, peripheral break, instruction and load/store breaks, core events
// - entry needs debug enabled, a cause bit and its enable bit
// - on entry wait for an empty pipeline before port fetch
// - reading the cause register clears it
module debug_mode_control
  import debug_ctl_pkg::*;
(
  // clock and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 reset,
  // register port
  input  wire logic [debug_ctl_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [debug_ctl_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [debug_ctl_pkg::DATA_W-1:0]     reg_rdata,
  // development port pins
  input  wire logic                                 soft_reset_pin_n,
  input  wire logic                                 debug_serial_clock_pin,
  input  wire logic                                 debug_serial_in_pin,
  output logic                                      debug_serial_out_pin,
  // core status and events
  input  wire logic [debug_ctl_pkg::CORE_EV_W-1:0]  core_event,
  input  wire logic                                 periph_break,
  input  wire logic                                 ext_irq_enable,
  input  wire logic                                 recoverable,
  input  wire logic                                 core_privilege,
  input  wire logic                                 pipeline_empty,
  input  wire logic                                 rfi_exec,
  input  wire logic [debug_ctl_pkg::DATA_W-1:0]     core_pc,
  input  wire logic                                 iw_hit,
  input  wire logic                                 ls_hit,
  // core control
  output logic                                      debug_enable,
  output logic                                      in_debug,
  output logic                                      fetch_from_port,
  output logic                                      privilege_level_bit,
  output logic      [debug_ctl_pkg::DATA_W-1:0]     instr_word,
  output logic                                      instr_valid,
  output logic      [debug_ctl_pkg::DATA_W-1:0]     resume_pc,
  output logic                                      resume_go,
  output logic                                      vector_req,
  output logic                                      instr_break,
  output logic                                      inhibit_exec,
  output logic                                      ls_break,
  output logic                                      vsync,
  output logic                                      cause_or
);
  localparam int FRAME_BITS = DATA_W + 1;
  localparam logic [5:0] LAST_BIT = 6'(FRAME_BITS - 1);
  localparam logic [3:0] HOLD_CNT = 4'(ENTRY_HOLD);

  // pin synchronisers
  logic srst_s1, srst_s2, srst_d;
  logic debug_serial_clock_pin_s1, debug_serial_clock_pin_s2, debug_serial_clock_pin_d;
  logic din_s1, din_s2;
  logic [SAMPLE_LEAD-1:0] debug_serial_clock_pin_hist;

  // reset capture
  logic       post_run;
  logic [3:0] post_cnt;
  logic       reset_entry;

  // serial port
  logic                  rx_busy;
  logic [5:0]            rx_cnt;
  logic [FRAME_BITS-1:0] rx_shift;
  logic [FRAME_BITS-1:0] tx_shift;
  logic [DATA_W-1:0]     tx_data;
  logic [DATA_W-1:0]     rx_word;
  logic                  port_ite, port_lte;
  logic                  port_nm_req, port_m_req;

  // registers
  logic              sw_ite, sw_lte;
  logic [DATA_W-1:0] cause;
  logic [DATA_W-1:0] den;
  logic [CNT_W-1:0]  cnt_i, cnt_l;
  dbg_state_t        state, next_state;

  function automatic logic [DATA_W-1:0] te_word(input logic sw, input logic port);
    logic [DATA_W-1:0] w;
    w = '0;
    w[TE_SW_BIT]   = sw;
    w[TE_PORT_BIT] = port;
    return w;
  endfunction : te_word

  // decode
  wire wr_instruction_support_control  = reg_wr && reg_addr == ADDR_INSTRUCTION_SUPPORT_CONTROL;
  wire wr_lctrl  = reg_wr && reg_addr == ADDR_LCTRL;
  wire wr_den    = reg_wr && reg_addr == ADDR_DEN;
  wire wr_cnt_i  = reg_wr && reg_addr == ADDR_CNT_I;
  wire wr_cnt_l  = reg_wr && reg_addr == ADDR_CNT_L;
  wire wr_pdata  = reg_wr && reg_addr == ADDR_PDATA;
  wire rd_cause  = reg_rd && reg_addr == ADDR_CAUSE;
  wire priv_ok   = !privilege_level_bit;

  // reset pin edges; negation is the rising edge of the active-low pin
  wire srst_release = srst_s2 && !srst_d;
  wire in_soft_reset = !srst_s2;

  // serial clock edge and frame end
  wire debug_serial_clock_pin_rise  = debug_serial_clock_pin_s2 && !debug_serial_clock_pin_d;
  wire rx_start   = debug_serial_clock_pin_rise && !rx_busy && din_s2;
  wire rx_shiftin = debug_serial_clock_pin_rise && rx_busy;
  wire rx_done    = rx_shiftin && rx_cnt == LAST_BIT;
  wire [FRAME_BITS-1:0] rx_frame = {rx_shift[FRAME_BITS-2:0], din_s2};
  wire frame_ctl  = rx_frame[FRAME_BITS-1];
  wire [DATA_W-1:0] frame_pl = rx_frame[DATA_W-1:0];
  wire te_frame   = rx_done && frame_ctl;
  wire dbg_frame  = rx_done && !frame_ctl;

  // effective trap enables
  wire ite_eff = sw_ite | port_ite;
  wire lte_eff = sw_lte | port_lte;

  // breakpoint counters, active whether or not debug is enabled
  wire i_cnt_live = iw_hit && cnt_i != '0;
  wire i_cnt_one  = i_cnt_live && cnt_i == CNT_W'(1);
  wire l_cnt_live = ls_hit && cnt_l != '0;
  wire l_cnt_one  = l_cnt_live && cnt_l == CNT_W'(1);

  assign instr_break  = i_cnt_one && ite_eff;
  assign inhibit_exec = instr_break;
  assign ls_break     = l_cnt_one && lte_eff;

  // new cause events
  wire [DATA_W-1:0] new_ev;
  assign new_ev[CAUSE_PORT_NM] = port_nm_req || reset_entry;
  assign new_ev[CAUSE_PORT_M]  = port_m_req && ext_irq_enable;
  assign new_ev[CAUSE_PERIPH]  = periph_break && recoverable;
  assign new_ev[CAUSE_IBRK]    = instr_break;
  assign new_ev[CAUSE_LBRK]    = ls_break;
  assign new_ev[CORE_EV_W-1:0] = core_event;

  // events not routed to debug branch to their vectors
  wire [DATA_W-1:0] route = debug_enable ? den : '0;
  assign vector_req = |(new_ev & ~route);

  wire [DATA_W-1:0] next_cause = (rd_cause ? '0 : cause) | new_ev;
  wire enter_req = debug_enable && |(cause & den);

  // state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_NORMAL: if (enter_req) next_state = ST_DRAIN;
      ST_DRAIN:  if (pipeline_empty) next_state = ST_DEBUG;
      ST_DEBUG:  if (rfi_exec) next_state = ST_NORMAL;
      default:   next_state = ST_NORMAL;
    endcase
  end

  assign in_debug            = state == ST_DEBUG;
  assign fetch_from_port     = in_debug;
  assign privilege_level_bit = in_debug ? 1'b0 : core_privilege;
  assign cause_or            = |cause;
  assign debug_serial_out_pin = tx_shift[FRAME_BITS-1];

  // read mux
  wire [DATA_W-1:0] status_word = DATA_W'({in_debug, debug_enable});
  wire [DATA_W-1:0] rd_mux =
    reg_addr == ADDR_INSTRUCTION_SUPPORT_CONTROL  ? te_word(sw_ite, port_ite) :
    reg_addr == ADDR_LCTRL  ? te_word(sw_lte, port_lte) :
    reg_addr == ADDR_CAUSE  ? cause :
    reg_addr == ADDR_DEN    ? den :
    reg_addr == ADDR_CNT_I  ? DATA_W'(cnt_i) :
    reg_addr == ADDR_CNT_L  ? DATA_W'(cnt_l) :
    reg_addr == ADDR_PDATA  ? rx_word :
    reg_addr == ADDR_STATUS ? status_word : '0;

  // two flip-flops before any logic reads a pin
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // idle high, so leaving system reset is not taken for a soft reset negation
      {srst_s1, srst_s2, srst_d} <= 3'h7;
      {debug_serial_clock_pin_s1, debug_serial_clock_pin_s2, debug_serial_clock_pin_d} <= 3'h0;
      {din_s1, din_s2}           <= 2'h0;
      debug_serial_clock_pin_hist                  <= '0;
    end else begin
      srst_s1   <= soft_reset_pin_n;
      srst_s2   <= srst_s1;
      srst_d    <= srst_s2;
      debug_serial_clock_pin_s1   <= debug_serial_clock_pin;
      debug_serial_clock_pin_s2   <= debug_serial_clock_pin_s1;
      debug_serial_clock_pin_d    <= debug_serial_clock_pin_s2;
      din_s1    <= debug_serial_in_pin;
      din_s2    <= din_s1;
      debug_serial_clock_pin_hist <= {debug_serial_clock_pin_hist[SAMPLE_LEAD-2:0], debug_serial_clock_pin_s2};
    end
  end

  // debug enable latched only at soft reset negation; both pins share the
  // same synchroniser delay so the history tap lines up with the pin
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      debug_enable <= 1'b0;
    end else if (srst_release) begin
      debug_enable <= debug_serial_clock_pin_hist[SAMPLE_LEAD-1];
    end
  end

  // serial clock still high after the hold window means entry from reset
  always_ff @(posedge clk_sys) begin
    if (reset || in_soft_reset) begin
      post_run    <= 1'b0;
      post_cnt    <= 4'h0;
      reset_entry <= 1'b0;
    end else begin
      reset_entry <= 1'b0;
      if (srst_release) begin
        post_run <= 1'b1;
        post_cnt <= 4'h0;
      end else if (post_run) begin
        post_cnt <= post_cnt + 4'h1;
        if (post_cnt == HOLD_CNT) begin
          post_run    <= 1'b0;
          reset_entry <= debug_enable && debug_serial_clock_pin_s2;
        end
      end
    end
  end

  // serial receive and full-duplex transmit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_busy  <= 1'b0;
      rx_cnt   <= 6'h00;
      rx_shift <= '0;
      tx_shift <= '0;
    end else if (rx_start) begin
      rx_busy  <= 1'b1;
      rx_cnt   <= 6'h00;
      tx_shift <= {cause_or, tx_data};
    end else if (rx_shiftin) begin
      rx_shift <= rx_frame;
      tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
      rx_cnt   <= rx_cnt + 6'h01;
      if (rx_done) begin
        rx_busy <= 1'b0;
      end
    end
  end

  // port trap enables and controls, taken only from a whole frame
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_ite    <= 1'b0;
      port_lte    <= 1'b0;
      port_nm_req <= 1'b0;
      port_m_req  <= 1'b0;
      vsync       <= 1'b0;
    end else begin
      port_nm_req <= te_frame && frame_pl[PL_NMBK];
      port_m_req  <= te_frame && frame_pl[PL_MBK];
      if (te_frame) begin
        port_ite <= frame_pl[PL_ITE];
        port_lte <= frame_pl[PL_LTE];
        if (frame_pl[PL_VS_LO+1:PL_VS_LO] == VSYNC_ON) begin
          vsync <= 1'b1;
        end else if (frame_pl[PL_VS_LO+1:PL_VS_LO] == VSYNC_OFF) begin
          vsync <= 1'b0;
        end
      end
    end
  end

  // instruction words from the port; data frames outside debug only load rx_word and issue no instruction
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      instr_word  <= '0;
      instr_valid <= 1'b0;
      rx_word     <= '0;
    end else begin
      instr_valid <= dbg_frame && in_debug;
      if (dbg_frame) begin
        rx_word <= frame_pl;
        if (in_debug) begin
          instr_word <= frame_pl;
        end
      end
    end
  end

  // software registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sw_ite  <= 1'b0;
      sw_lte  <= 1'b0;
      den     <= DEN_RESET;
      tx_data <= '0;
    end else begin
      if (wr_instruction_support_control && priv_ok) begin
        sw_ite <= reg_wdata[TE_SW_BIT];
      end
      if (wr_lctrl && priv_ok) begin
        sw_lte <= reg_wdata[TE_SW_BIT];
      end
      if (wr_den) begin
        den <= reg_wdata;
      end
      if (wr_pdata) begin
        tx_data <= reg_wdata;
      end
    end
  end

  // counters: software write wins over a count in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_i <= CNT_RESET;
      cnt_l <= CNT_RESET;
    end else begin
      if (wr_cnt_i) begin
        cnt_i <= reg_wdata[CNT_W-1:0];
      end else if (i_cnt_live && !i_cnt_one) begin
        cnt_i <= cnt_i - CNT_W'(1);
      end
      if (wr_cnt_l) begin
        cnt_l <= reg_wdata[CNT_W-1:0];
      end else if (l_cnt_live) begin
        cnt_l <= cnt_l - CNT_W'(1);
      end
    end
  end

  // cause register, state, resume point and read data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cause     <= '0;
      state     <= ST_NORMAL;
      resume_pc <= '0;
      resume_go <= 1'b0;
      reg_rdata <= '0;
    end else begin
      cause     <= next_cause;
      state     <= next_state;
      resume_go <= in_debug && rfi_exec;
      reg_rdata <= reg_rd ? rd_mux : '0;
      if (state == ST_DRAIN && pipeline_empty) begin
        resume_pc <= core_pc;
      end
    end
  end
endmodule : debug_mode_control

// ### bench/debug_mode_control_checker.sv
// port assertions for the debug mode control block
`timescale 1ns/10ps
module debug_mode_control_checker (
  // clock and reset
  input wire logic                                clk_sys,
  input wire logic                                reset,
  // causes
  input wire logic [debug_ctl_pkg::ADDR_W-1:0]    reg_addr,
  input wire logic                                reg_rd,
  input wire logic                                soft_reset_pin_n,
  input wire logic [debug_ctl_pkg::CORE_EV_W-1:0] core_event,
  input wire logic                                periph_break,
  input wire logic                                iw_hit,
  input wire logic                                ls_hit,
  input wire logic                                rfi_exec,
  input wire logic                                pipeline_empty,
  // watched outputs
  input wire logic                                debug_enable,
  input wire logic                                in_debug,
  input wire logic                                fetch_from_port,
  input wire logic                                privilege_level_bit,
  input wire logic                                resume_go,
  input wire logic                                vector_req,
  input wire logic                                instr_break,
  input wire logic                                inhibit_exec,
  input wire logic                                ls_break,
  input wire logic                                cause_or
);
  import debug_ctl_pkg::*;
  // cycles since soft reset pin rose; the mode may only move just after it
  logic [3:0] hi_cnt;
  logic       quiet;
  assign quiet = (core_event == '0) && !periph_break && !iw_hit && !ls_hit;
  always_ff @(posedge clk_sys) begin
    if (reset || !soft_reset_pin_n) begin
      hi_cnt <= 4'h0;
    end else if (hi_cnt != 4'hf) begin
      hi_cnt <= hi_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_rfi_taken;
    in_debug && rfi_exec;
  endsequence
  sequence s_resumed;
    resume_go && !in_debug;
  endsequence
  AST_RFI_RESUME: assert property (s_rfi_taken |=> s_resumed)
    else $error("rfi in debug did not resume normal mode");
  AST_MODE_ONCE: assert property ($changed(debug_enable) |-> hi_cnt < 4'h8)
    else $error("debug enable moved outside soft reset negation");
  AST_ENTRY_NEEDS_EN: assert property (!debug_enable |-> !in_debug)
    else $error("in debug while debug mode disabled");
  AST_DRAIN_FIRST: assert property ($rose(in_debug) |-> $past(pipeline_empty))
    else $error("debug entered with busy pipeline");
  AST_PRIV_FORCED: assert property (in_debug |-> !privilege_level_bit)
    else $error("privilege not forced in debug");
  AST_PORT_FETCH: assert property (fetch_from_port == in_debug)
    else $error("fetch source differs from debug state");
  AST_CAUSE_SUM: assert property (core_event != '0 |=> cause_or)
    else $error("cause summary missed an event");
  AST_CAUSE_CLEAR: assert property (
    reg_rd && reg_addr == ADDR_CAUSE && quiet |=> !cause_or)
    else $error("cause read did not clear");
  AST_IBRK: assert property (instr_break |-> iw_hit && inhibit_exec)
    else $error("instruction break without hit or inhibit");
  AST_LBRK: assert property (ls_break |-> ls_hit)
    else $error("load store break without hit");
  AST_VEC_OFF: assert property (!debug_enable && core_event != '0 |-> vector_req)
    else $error("event not vectored with debug disabled");
endmodule : debug_mode_control_checker

bind debug_mode_control debug_mode_control_checker i_debug_mode_control_checker (
  .clk_sys, .reset, .reg_addr, .reg_rd, .soft_reset_pin_n, .core_event,
  .periph_break, .iw_hit, .ls_hit, .rfi_exec, .pipeline_empty, .debug_enable,
  .in_debug, .fetch_from_port, .privilege_level_bit, .resume_go, .vector_req,
  .instr_break, .inhibit_exec, .ls_break, .cause_or
);

// ### bench/dev_tool_model.sv
// tool side of the development port: soft reset and serial frames
`timescale 1ns/10ps
module dev_tool_model (
  // pins toward the device
  output logic      soft_reset_pin_n,
  output logic      debug_serial_clock_pin,
  output logic      debug_serial_in_pin,
  // pin from the device
  input  wire logic debug_serial_out_pin
);
  localparam int HALF_NS = 32;
  logic [33:0] frame;
  // device reply, taken on each falling clock edge but the last: cause summary, then tx word
  logic [32:0] reply;
  initial begin
    soft_reset_pin_n = 1'b1;
    debug_serial_clock_pin = 1'b0;
    debug_serial_in_pin = 1'b0;
  end
  // data held low so the clock rise in reset cannot start a frame
  task automatic soft_reset(input logic sck_high, input int hold_ns);
    soft_reset_pin_n = 1'b0;
    debug_serial_in_pin = 1'b0;
    debug_serial_clock_pin = sck_high;
    #200;
    soft_reset_pin_n = 1'b1;
    #(hold_ns);
    debug_serial_clock_pin = 1'b0;
  endtask : soft_reset
  // start bit, control bit, then payload msb first; clock stands low between
  task automatic send_frame(input logic ctl, input logic [31:0] payload);
    frame = {1'b1, ctl, payload};
    for (int i = 33; i >= 0; i--) begin
      debug_serial_in_pin = frame[i];
      #(HALF_NS) debug_serial_clock_pin = 1'b1;
      #(HALF_NS);
      if (i > 0) begin
        reply[i-1] = debug_serial_out_pin;
      end
      debug_serial_clock_pin = 1'b0;
    end
    // no pull on the data line: once released it shows the inverse
    debug_serial_in_pin = ~frame[0];
  endtask : send_frame
endmodule : dev_tool_model

// ### bench/debug_mode_control_tb_top.sv
// self-checking bench for the debug mode control block
`timescale 1ns/10ps
module debug_mode_control_tb_top;
  import debug_ctl_pkg::*;
  logic                 clk_sys, reset, reg_wr, reg_rd, soft_reset_pin_n;
  logic                 debug_serial_clock_pin, debug_serial_in_pin, debug_serial_out_pin;
  logic                 periph_break, ext_irq_enable, recoverable, core_privilege;
  logic                 pipeline_empty, rfi_exec, iw_hit, ls_hit, debug_enable, in_debug;
  logic                 fetch_from_port, privilege_level_bit, instr_valid, resume_go;
  logic                 vector_req, instr_break, inhibit_exec, ls_break, vsync, cause_or;
  logic [ADDR_W-1:0]    reg_addr;
  logic [CORE_EV_W-1:0] core_event;
  logic [DATA_W-1:0]    reg_wdata, reg_rdata, core_pc, instr_word, resume_pc, rdata;
  int                   n_mismatch, compares;
  debug_mode_control i_debug_mode_control (
    .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .soft_reset_pin_n, .debug_serial_clock_pin, .debug_serial_in_pin,
    .debug_serial_out_pin, .core_event, .periph_break, .ext_irq_enable, .recoverable,
    .core_privilege, .pipeline_empty, .rfi_exec, .core_pc, .iw_hit, .ls_hit,
    .debug_enable, .in_debug, .fetch_from_port, .privilege_level_bit, .instr_word,
    .instr_valid, .resume_pc, .resume_go, .vector_req, .instr_break, .inhibit_exec,
    .ls_break, .vsync, .cause_or
  );
  dev_tool_model i_dev_tool_model (
    .soft_reset_pin_n, .debug_serial_clock_pin, .debug_serial_in_pin, .debug_serial_out_pin
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp_word(input string what, input logic [DATA_W-1:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  task automatic cmp_bit(input string what, input logic exp, got);
    cmp_word(what, {31'h0, exp}, {31'h0, got});
  endtask : cmp_bit
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cycles
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the read edge
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rdata = reg_rdata;
  endtask : rd
  task automatic wait_sig(input logic pick, input logic lvl);
    int k;
    k = 0;
    while ((pick ? instr_valid : in_debug) !== lvl && k < 500) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == 500) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_sig
  task automatic hit(input logic on_ls, input logic exp);
    @(posedge clk_sys);
    iw_hit <= !on_ls;
    ls_hit <= on_ls;
    #1;
    cmp_bit("break", exp, on_ls ? ls_break : instr_break);
    @(posedge clk_sys);
    iw_hit <= 1'b0;
    ls_hit <= 1'b0;
  endtask : hit
  task automatic leave_debug;
    @(posedge clk_sys);
    rfi_exec <= 1'b1;
    @(posedge clk_sys);
    rfi_exec <= 1'b0;
    #1;
    cmp_bit("resume_go", 1'b1, resume_go);
    cmp_bit("in_debug", 1'b0, in_debug);
  endtask : leave_debug
  task automatic s_disabled;
    i_dev_tool_model.soft_reset(1'b0, 0);
    cycles(20);
    cmp_bit("debug_enable", 1'b0, debug_enable);
    rd(ADDR_DEN);
    cmp_word("den", DEN_RESET, rdata);
    rd(ADDR_CNT_I);
    cmp_word("cnt_i", {16'h0, CNT_RESET}, rdata);
    rd(4'h8);
    cmp_word("unmapped", 32'h0, rdata);
    @(posedge clk_sys);
    core_event <= 27'h1;
    periph_break <= 1'b1;
    #1;
    cmp_bit("vector_req", 1'b1, vector_req);
    @(posedge clk_sys);
    core_event <= 27'h0;
    periph_break <= 1'b0;
    rd(ADDR_CAUSE);
    cmp_word("cause", 32'h1, rdata);
    rd(ADDR_CAUSE);
    cmp_word("cause clear", 32'h0, rdata);
  endtask : s_disabled
  // breakpoint hardware stays usable with debug mode off
  task automatic s_traps;
    @(posedge clk_sys);
    core_privilege <= 1'b1;
    wr(ADDR_INSTRUCTION_SUPPORT_CONTROL, 32'h1);
    rd(ADDR_INSTRUCTION_SUPPORT_CONTROL);
    cmp_word("instruction_support_control locked", 32'h0, rdata);
    @(posedge clk_sys);
    core_privilege <= 1'b0;
    wr(ADDR_INSTRUCTION_SUPPORT_CONTROL, 32'h1);
    i_dev_tool_model.send_frame(1'b1, 32'h1);
    cycles(10);
    rd(ADDR_INSTRUCTION_SUPPORT_CONTROL);
    cmp_word("instruction_support_control both", 32'h3, rdata);
    wr(ADDR_INSTRUCTION_SUPPORT_CONTROL, 32'h0);
    wr(ADDR_CNT_I, 32'h2);
    hit(1'b0, 1'b0);
    hit(1'b0, 1'b1);
    rd(ADDR_CNT_I);
    cmp_word("cnt_i", 32'h1, rdata);
    i_dev_tool_model.send_frame(1'b1, 32'h0);
    cmp_bit("reply cause_or", 1'b1, i_dev_tool_model.reply[32]);
    cmp_word("reply word", 32'h0, i_dev_tool_model.reply[31:0]);
    cycles(10);
    hit(1'b0, 1'b0);
    wr(ADDR_LCTRL, 32'h1);
    wr(ADDR_CNT_L, 32'h1);
    hit(1'b1, 1'b1);
    rd(ADDR_CNT_L);
    cmp_word("cnt_l", 32'h0, rdata);
  endtask : s_traps
  task automatic s_frames;
    i_dev_tool_model.send_frame(1'b1, {26'h0, VSYNC_ON, 4'h0});
    cycles(10);
    cmp_bit("vsync on", 1'b1, vsync);
    // both port breaks with interrupts off: only the nonmaskable one is recorded
    i_dev_tool_model.send_frame(1'b1, {26'h0, VSYNC_OFF, 4'hc});
    cycles(10);
    cmp_bit("vsync off", 1'b0, vsync);
    i_dev_tool_model.send_frame(1'b1, 32'h0);
    cycles(10);
    rd(ADDR_CAUSE);
    cmp_word("cause port", 32'h98000000, rdata);
  endtask : s_frames
  task automatic s_session;
    i_dev_tool_model.soft_reset(1'b1, 10);
    cycles(20);
    cmp_bit("debug_enable", 1'b1, debug_enable);
    cmp_bit("idle", 1'b0, in_debug);
    @(posedge clk_sys);
    pipeline_empty <= 1'b0;
    core_pc <= 32'h00001230;
    core_privilege <= 1'b1;
    core_event <= 27'h2;
    @(posedge clk_sys);
    core_event <= 27'h0;
    cycles(5);
    cmp_bit("drain", 1'b0, in_debug);
    cmp_bit("cause_or", 1'b1, cause_or);
    pipeline_empty <= 1'b1;
    wait_sig(1'b0, 1'b1);
    cmp_bit("privilege", 1'b0, privilege_level_bit);
    cmp_word("resume_pc", 32'h00001230, resume_pc);
    rd(ADDR_STATUS);
    cmp_word("status", 32'h3, rdata);
    rd(ADDR_CAUSE);
    cmp_word("cause", 32'h2, rdata);
    wr(ADDR_PDATA, 32'hc3a50001);
    fork
      i_dev_tool_model.send_frame(1'b0, 32'h5a5a0f0f);
      begin
        wait_sig(1'b1, 1'b1);
        cmp_word("instr_word", 32'h5a5a0f0f, instr_word);
      end
    join
    cmp_bit("reply cause_or", 1'b0, i_dev_tool_model.reply[32]);
    cmp_word("reply word", 32'hc3a50001, i_dev_tool_model.reply[31:0]);
    rd(ADDR_PDATA);
    cmp_word("rx word", 32'h5a5a0f0f, rdata);
    leave_debug();
  endtask : s_session
  task automatic s_reset_entry;
    i_dev_tool_model.soft_reset(1'b1, 100);
    wait_sig(1'b0, 1'b1);
    rd(ADDR_CAUSE);
    cmp_word("reset entry", 32'h80000000, rdata);
    leave_debug();
    i_dev_tool_model.soft_reset(1'b0, 0);
    cycles(20);
    cmp_bit("debug_enable", 1'b0, debug_enable);
  endtask : s_reset_entry
  initial begin
    {reset, reg_wr, reg_rd, periph_break, ext_irq_enable, recoverable} = 6'h20;
    {core_privilege, rfi_exec, iw_hit, ls_hit, pipeline_empty} = 5'h01;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    core_pc = 32'h0;
    core_event = 27'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    s_disabled();
    s_traps();
    s_frames();
    s_session();
    s_reset_entry();
    report_and_stop();
  end
endmodule : debug_mode_control_tb_top
